/* rtl/pgeu_defs.vh */
// Purpose: constants for the event unit control block
// Assumes: apb with 32-bit data, byte addresses
// Notes: definitions only
`ifndef PGEU_DEFS_VH
`define PGEU_DEFS_VH
`define PGEU_ADDR_W 12
`define PGEU_OFF_INDEX 12'h520
`define PGEU_OFF_IRQ_STATUS 12'h528
`define PGEU_OFF_CTRL 12'h52c
`define PGEU_OFF_IRQ_MASK 12'h540
`define PGEU_OFF_EVENTS 12'h544
`define PGEU_ST_PULSE_LSB 16
`define PGEU_ST_PULSE_MSB 18
`define PGEU_ST_CAP_MSB 1
`define PGEU_CTL_OUT_SEL 8
`define PGEU_CTL_PIN_IN 7
`define PGEU_CTL_DIR 6
`define PGEU_CTL_CAP_IRQ_EN 5
`define PGEU_CTL_ACTIVE 4
`define PGEU_CTL_ARM 3
`define PGEU_CTL_SOFT_RST 2
`define PGEU_CTL_CAP_EN 1
`define PGEU_IDX_CAP 8
`define PGEU_IDX_PULSE_MSB 1
`define PGEU_PULSE_RESERVED 2'h3
`define PGEU_CNT_W 4
`endif

/* rtl/pgeu_event_unit_ctrl.v */
// Purpose: status and control of three pulse output units and two capture units on one gpio pin
// Assumes: apb slave, single clock, synchronous active-high reset
// Notes: unit events arrive as one-cycle pulses from the unit datapaths on this clock
//
// Operation
// - summary gpio event interrupt is the or of all held unit flags
// - status bits 18:16 are pulse unit flags, reset zero
// - pulse unit flag sets only when that unit's report enable is set
// - status bits 1:0 are capture unit flags, reset zero
// - capture unit flag sets only with its own capture interrupt enable
// - control bit 8 picks combinational or registered pin output, reset zero
// - bit 7 reads the synchronised pin input level
// - bit 6 selects pin as capture input when one, output when zero
// - bit 5 is the interrupt enable of the indexed capture unit
// - bit 4 reads one while indexed pulse unit runs without error
// - writing one to bit 3 arms indexed pulse unit; clears on output
// - bit 2 returns indexed pulse unit to inactive default state
// - pulse fields use index bits 1:0, capture fields index bit 8
// - writing one to bit 1 enables capture unit, clears its counter
// - writing zero to bit 1 disables unit, clears ready and overflow
// - pulse pointer codes 0..2 select units, 3 reserved; capture pointer one bit
// - late-target error clears when software clears the arm bit
//
// Our own choice: the APB register port.
`timescale 1ns/1ps
`include "pgeu_defs.vh"
module pgeu_event_unit_ctrl (
  // clock and reset
  input wire clk_i,
  input wire srst_i,
  // apb slave
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [`PGEU_ADDR_W-1:0] paddr_i,
  input wire [31:0] pwdata_i,
  output wire pready_o,
  output wire pslverr_o,
  output reg [31:0] prdata_o,
  // gpio pin: oe low while driving
  input wire gpio_pin_i,
  output reg gpio_pin_o,
  output wire gpio_pin_oe_o,
  // pulse unit datapath
  input wire [2:0] pulse_report_enable_i,
  input wire [2:0] pulse_fire_i,
  input wire [2:0] pulse_late_i,
  input wire pulse_level_i,
  input wire [2:0] cascade_arm_i,
  output wire [2:0] pulse_unit_arm_o,
  output reg [2:0] pulse_unit_soft_reset_o,
  // capture unit datapath
  input wire [1:0] capture_event_i,
  output wire [1:0] capture_unit_enable_o,
  output wire [1:0] capture_ready_flag_o,
  output wire [1:0] capture_count_overflow_o,
  output wire [2*`PGEU_CNT_W-1:0] capture_event_count_o,
  // interrupts
  output wire gpio_event_irq_o,
  output wire irq_o
);
  // pin input synchroniser; only the second stage is read
  reg pin_meta;
  reg pin_sync;
  reg [1:0] pulse_unit_pointer;
  reg capture_unit_pointer;
  reg out_sel;
  reg pin_direction_select;
  reg [1:0] capture_irq_enable;
  reg [2:0] arm;
  reg [2:0] active;
  reg [2:0] late_err;
  reg [2:0] pulse_flag;
  reg [1:0] cap_flag;
  reg [1:0] cap_en;
  reg [1:0] cap_rdy;
  reg [1:0] cap_ovf;
  reg [`PGEU_CNT_W-1:0] cap_cnt [0:1];
  reg [31:0] irq_mask;
  reg pulse_q;
  wire acc = psel_i & penable_i;
  wire wr = acc & pwrite_i;
  wire wr_ctrl = wr & (paddr_i == `PGEU_OFF_CTRL);
  wire wr_idx = wr & (paddr_i == `PGEU_OFF_INDEX);
  wire wr_stat = wr & (paddr_i == `PGEU_OFF_IRQ_STATUS);
  wire wr_mask = wr & (paddr_i == `PGEU_OFF_IRQ_MASK);
  // reserved pointer code hits no unit
  wire ptr_ok = (pulse_unit_pointer != `PGEU_PULSE_RESERVED);
  wire [31:0] status;
  wire mapped = (paddr_i == `PGEU_OFF_INDEX) | (paddr_i == `PGEU_OFF_IRQ_STATUS) |
                (paddr_i == `PGEU_OFF_CTRL) | (paddr_i == `PGEU_OFF_IRQ_MASK);
  assign pready_o = 1'b1;
  assign pslverr_o = acc & ~mapped;
  assign status = {13'h0000, pulse_flag, 14'h0000, cap_flag};
  assign gpio_event_irq_o = |status;
  assign irq_o = |(status & irq_mask);
  assign gpio_pin_oe_o = pin_direction_select;
  assign pulse_unit_arm_o = arm;
  assign capture_unit_enable_o = cap_en;
  assign capture_ready_flag_o = cap_rdy;
  assign capture_count_overflow_o = cap_ovf;
  assign capture_event_count_o = {cap_cnt[1], cap_cnt[0]};
  always @* begin
    if (out_sel) begin
      gpio_pin_o = pulse_level_i;
    end else begin
      gpio_pin_o = pulse_q;
    end
  end
  always @(posedge clk_i) begin
    if (srst_i) begin
      pin_meta <= 1'b0;
      pin_sync <= 1'b0;
      pulse_q <= 1'b0;
      pulse_unit_pointer <= 2'h0;
      capture_unit_pointer <= 1'b0;
      out_sel <= 1'b0;
      pin_direction_select <= 1'b0;
      capture_irq_enable <= 2'h0;
      irq_mask <= 32'h00000000;
    end else begin
      pin_meta <= gpio_pin_i;
      pin_sync <= pin_meta;
      pulse_q <= pulse_level_i;
      if (wr_idx) begin
        pulse_unit_pointer <= pwdata_i[`PGEU_IDX_PULSE_MSB:0];
        capture_unit_pointer <= pwdata_i[`PGEU_IDX_CAP];
      end
      if (wr_mask) begin
        irq_mask <= pwdata_i & 32'h00070003;
      end
      if (wr_ctrl) begin
        out_sel <= pwdata_i[`PGEU_CTL_OUT_SEL];
        pin_direction_select <= pwdata_i[`PGEU_CTL_DIR];
        capture_irq_enable[capture_unit_pointer] <= pwdata_i[`PGEU_CTL_CAP_IRQ_EN];
      end
    end
  end
  // per pulse unit state
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_pulse
      wire sel = ptr_ok & (pulse_unit_pointer == g);
      wire sw_rst = wr_ctrl & sel & pwdata_i[`PGEU_CTL_SOFT_RST];
      always @(posedge clk_i) begin
        if (srst_i) begin
          arm[g] <= 1'b0;
          active[g] <= 1'b0;
          late_err[g] <= 1'b0;
          pulse_flag[g] <= 1'b0;
          pulse_unit_soft_reset_o[g] <= 1'b0;
        end else begin
          pulse_unit_soft_reset_o[g] <= sw_rst;
          if (sw_rst) begin
            arm[g] <= 1'b0;
            active[g] <= 1'b0;
            late_err[g] <= 1'b0;
          end else begin
            if (pulse_fire_i[g]) begin
              arm[g] <= 1'b0;
            end else if ((wr_ctrl & sel) | cascade_arm_i[g]) begin
              arm[g] <= (wr_ctrl & sel) ? pwdata_i[`PGEU_CTL_ARM] : 1'b1;
            end
            if (pulse_late_i[g] | pulse_fire_i[g]) begin
              active[g] <= 1'b0;
            end else if ((wr_ctrl & sel & pwdata_i[`PGEU_CTL_ARM]) | cascade_arm_i[g]) begin
              active[g] <= 1'b1;
            end
            // late error cleared by arm write of zero; set wins
            if (pulse_late_i[g] & pulse_report_enable_i[g]) begin
              late_err[g] <= 1'b1;
            end else if (wr_ctrl & sel & ~pwdata_i[`PGEU_CTL_ARM]) begin
              late_err[g] <= 1'b0;
            end
          end
          // gated by report enable; set beats write-one clear
          if (pulse_report_enable_i[g] & (pulse_fire_i[g] | pulse_late_i[g])) begin
            pulse_flag[g] <= 1'b1;
          end else if (wr_stat & pwdata_i[`PGEU_ST_PULSE_LSB + g]) begin
            pulse_flag[g] <= 1'b0;
          end
        end
      end
    end
    for (g = 0; g < 2; g = g + 1) begin : g_cap
      wire sel = (capture_unit_pointer == g);
      wire wr_en = wr_ctrl & sel;
      always @(posedge clk_i) begin
        if (srst_i) begin
          cap_en[g] <= 1'b0;
          cap_rdy[g] <= 1'b0;
          cap_ovf[g] <= 1'b0;
          cap_flag[g] <= 1'b0;
          cap_cnt[g] <= {`PGEU_CNT_W{1'b0}};
        end else begin
          if (wr_en & pwdata_i[`PGEU_CTL_CAP_EN]) begin
            cap_en[g] <= 1'b1;
            cap_cnt[g] <= {`PGEU_CNT_W{1'b0}};
          end else if (wr_en) begin
            cap_en[g] <= 1'b0;
            cap_rdy[g] <= 1'b0;
            cap_ovf[g] <= 1'b0;
          end else if (cap_en[g] & pin_direction_select & capture_event_i[g]) begin
            cap_rdy[g] <= 1'b1;
            if (&cap_cnt[g]) begin
              cap_ovf[g] <= 1'b1;
            end else begin
              cap_cnt[g] <= cap_cnt[g] + {{(`PGEU_CNT_W-1){1'b0}}, 1'b1};
            end
          end
          // gated by own enable; input captures only
          if (capture_irq_enable[g] & cap_en[g] & pin_direction_select & capture_event_i[g]) begin
            cap_flag[g] <= 1'b1;
          end else if (wr_stat & pwdata_i[g]) begin
            cap_flag[g] <= 1'b0;
          end
        end
      end
    end
  endgenerate
  // read mux, registered so data comes from flops; reads with zero wait need ready high
  always @(posedge clk_i) begin
    if (srst_i) begin
      prdata_o <= 32'h00000000;
    end else if (psel_i & ~penable_i & ~pwrite_i) begin
      case (paddr_i)
        `PGEU_OFF_INDEX: prdata_o <= {23'h000000, capture_unit_pointer, 6'h00, pulse_unit_pointer};
        `PGEU_OFF_IRQ_STATUS: prdata_o <= status;
        `PGEU_OFF_IRQ_MASK: prdata_o <= irq_mask;
        `PGEU_OFF_CTRL: prdata_o <= {23'h000000, out_sel,
          pin_sync, pin_direction_select, capture_irq_enable[capture_unit_pointer],
          ptr_ok & active[pulse_unit_pointer], ptr_ok & arm[pulse_unit_pointer], 1'b0,
          cap_en[capture_unit_pointer], 1'b0};
        default: prdata_o <= 32'h00000000;
      endcase
    end
  end
endmodule

/* test/pgeu_ctrl_asserts.sv */
// Purpose: port checks of the event unit control block
// Assumes: zero wait apb, one clock
// Notes: bound by name to the top module
`timescale 1ns/1ps
`include "pgeu_defs.vh"
module pgeu_ctrl_asserts (
  // stimulus side
  input wire clk_i,
  input wire srst_i,
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [`PGEU_ADDR_W-1:0] paddr_i,
  input wire [31:0] pwdata_i,
  input wire [2:0] pulse_fire_i,
  input wire [2:0] pulse_report_enable_i,
  input wire [2:0] cascade_arm_i,
  // design outputs
  input wire [2:0] pulse_unit_arm_o,
  input wire [2:0] pulse_unit_soft_reset_o,
  input wire [1:0] capture_unit_enable_o,
  input wire [7:0] capture_event_count_o,
  input wire gpio_pin_oe_o,
  input wire gpio_event_irq_o,
  input wire irq_o
);
  wire wr_c = psel_i && penable_i && pwrite_i && paddr_i == `PGEU_OFF_CTRL;
  default clocking @(posedge clk_i); endclocking
  default disable iff (srst_i);
  irq_set_a: assert property (|(pulse_fire_i & pulse_report_enable_i) |=> gpio_event_irq_o)
    else $error("summary irq not set");
  irq_mask_a: assert property (irq_o |-> gpio_event_irq_o)
    else $error("irq without status");
  arm_clr_a: assert property (pulse_fire_i[1] && !wr_c && !cascade_arm_i[1] |=> !pulse_unit_arm_o[1])
    else $error("arm kept after fire");
  arm_rise_a: assert property ($rose(pulse_unit_arm_o[1]) |-> $past(wr_c && pwdata_i[3] || cascade_arm_i[1]))
    else $error("arm without cause");
  soft_src_a: assert property (|pulse_unit_soft_reset_o |-> $past(wr_c && pwdata_i[2]))
    else $error("soft reset without write");
  cap_en_a: assert property ($changed(capture_unit_enable_o) && !$past(srst_i) |-> $past(wr_c))
    else $error("capture enable moved alone");
  dir_src_a: assert property ($changed(gpio_pin_oe_o) && !$past(srst_i) |-> $past(wr_c))
    else $error("direction moved alone");
  cap_cnt_a: assert property ($rose(capture_unit_enable_o[1]) |-> ##[0:1] capture_event_count_o[7:4] == 4'h0)
    else $error("count not cleared");
  cover property ($rose(pulse_unit_arm_o[1]));
  cover property ($rose(irq_o));
  cover property (|pulse_unit_soft_reset_o);
endmodule
bind pgeu_event_unit_ctrl pgeu_ctrl_asserts chk_u (.*);

/* test/test_ptp_gpio_event_unit_control.sv */
// Purpose: directed register tests of the event unit control block
// Assumes: zero wait apb slave
// Notes: cascade arm is pulsed only for a non-head unit, software arms the head
`timescale 1ns/1ps
`include "pgeu_defs.vh"
module test_ptp_gpio_event_unit_control;
  reg clk_i = 0, srst_i = 1, psel_i = 0, penable_i = 0, pwrite_i = 0, gpio_pin_i = 0, pulse_level_i = 0;
  reg [`PGEU_ADDR_W-1:0] paddr_i = 0;
  reg [31:0] pwdata_i = 0, rd;
  reg [2:0] pulse_report_enable_i = 0, pulse_fire_i = 0, pulse_late_i = 0, cascade_arm_i = 0;
  reg [1:0] capture_event_i = 0;
  reg err;
  wire pready_o, pslverr_o, gpio_pin_o, gpio_pin_oe_o, gpio_event_irq_o, irq_o;
  wire [31:0] prdata_o;
  wire [2:0] pulse_unit_arm_o, pulse_unit_soft_reset_o;
  wire [1:0] capture_unit_enable_o, capture_ready_flag_o, capture_count_overflow_o;
  wire [7:0] capture_event_count_o;
  integer num_errors = 0, samples_checked = 0;
  pgeu_event_unit_ctrl dut_u (.*);
  always #4 clk_i = ~clk_i;
  task chk(input [31:0] seen, input [31:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (seen !== exp) begin
        num_errors = num_errors + 1;
        $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  // idle edge first so back to back calls never drive psel twice in one step
  task apb(input w, input [11:0] a, input [31:0] d);
    begin
      @(posedge clk_i);
      psel_i <= 1'b1;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge clk_i);
      penable_i <= 1'b1;
      @(posedge clk_i);
      while (pready_o !== 1'b1) @(posedge clk_i);
      rd = prdata_o;
      err = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
    end
  endtask
  task ev(input [2:0] f, input [2:0] l, input [1:0] c);
    begin
      @(posedge clk_i);
      pulse_fire_i <= f;
      pulse_late_i <= l;
      capture_event_i <= c;
      @(posedge clk_i);
      pulse_fire_i <= 3'h0;
      pulse_late_i <= 3'h0;
      capture_event_i <= 2'h0;
      @(negedge clk_i);
    end
  endtask
  task end_of_test;
    begin
      $display("errors %0d, checks %0d", num_errors, samples_checked);
      if (num_errors == 0 && samples_checked > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask
  initial begin
    #100000;
    num_errors = num_errors + 1;
    end_of_test;
  end
  initial begin
    repeat (20) @(posedge clk_i);
    srst_i <= 1'b0;
    apb(0, `PGEU_OFF_IRQ_STATUS, 0);
    chk(rd, 32'h0);
    apb(0, `PGEU_OFF_CTRL, 0);
    chk(rd, 32'h0);
    apb(0, `PGEU_OFF_EVENTS, 0);
    chk({rd[30:0], err}, 32'h1);
    pulse_report_enable_i <= 3'h5;
    ev(3'h4, 3'h3, 2'h0);
    chk({gpio_event_irq_o, irq_o}, 32'h2);
    apb(1, `PGEU_OFF_IRQ_MASK, 32'h70003);
    apb(0, `PGEU_OFF_IRQ_STATUS, 0);
    chk({rd, irq_o}, 33'h0a0001);
    apb(1, `PGEU_OFF_IRQ_STATUS, 32'h10000);
    apb(1, `PGEU_OFF_IRQ_STATUS, 32'h0);
    apb(0, `PGEU_OFF_IRQ_STATUS, 0);
    chk(rd, 32'h40000);
    apb(1, `PGEU_OFF_IRQ_STATUS, 32'h40000);
    @(negedge clk_i);
    chk({gpio_event_irq_o, irq_o}, 32'h0);
    apb(1, `PGEU_OFF_INDEX, 32'h1);
    apb(1, `PGEU_OFF_CTRL, 32'h8);
    apb(0, `PGEU_OFF_CTRL, 0);
    chk({rd, pulse_unit_arm_o}, 35'hc2);
    ev(3'h2, 3'h0, 2'h0);
    apb(0, `PGEU_OFF_CTRL, 0);
    chk({rd, pulse_unit_arm_o}, 35'h0);
    apb(1, `PGEU_OFF_INDEX, 32'h2);
    apb(1, `PGEU_OFF_CTRL, 32'h8);
    apb(1, `PGEU_OFF_CTRL, 32'h4);
    @(negedge clk_i);
    chk(pulse_unit_soft_reset_o, 32'h4);
    apb(0, `PGEU_OFF_CTRL, 0);
    chk(rd, 32'h0);
    apb(1, `PGEU_OFF_INDEX, 32'h3);
    apb(1, `PGEU_OFF_CTRL, 32'h8);
    @(negedge clk_i);
    chk(pulse_unit_arm_o, 32'h0);
    chk(pready_o, 32'h1);
    // software arms the head only; the next unit is armed by the chain
    apb(1, `PGEU_OFF_INDEX, 32'h0);
    apb(1, `PGEU_OFF_CTRL, 32'h8);
    @(posedge clk_i);
    cascade_arm_i <= 3'h2;
    @(posedge clk_i);
    cascade_arm_i <= 3'h0;
    @(negedge clk_i);
    chk(pulse_unit_arm_o, 32'h3);
    apb(1, `PGEU_OFF_CTRL, 32'h4);
    @(negedge clk_i);
    chk(pulse_unit_arm_o, 32'h2);
    apb(1, `PGEU_OFF_INDEX, 32'h100);
    apb(1, `PGEU_OFF_CTRL, 32'h62);
    ev(3'h0, 3'h0, 2'h3);
    chk({capture_unit_enable_o, gpio_pin_oe_o, capture_event_count_o}, 32'h510);
    apb(0, `PGEU_OFF_IRQ_STATUS, 0);
    chk(rd, 32'h2);
    apb(1, `PGEU_OFF_CTRL, 32'h62);
    @(negedge clk_i);
    chk(capture_event_count_o, 32'h0);
    apb(1, `PGEU_OFF_CTRL, 32'h40);
    @(negedge clk_i);
    chk({capture_unit_enable_o, capture_ready_flag_o, capture_count_overflow_o}, 32'h0);
    @(posedge clk_i);
    gpio_pin_i <= 1'b1;
    apb(1, `PGEU_OFF_CTRL, 32'h100);
    apb(0, `PGEU_OFF_CTRL, 0);
    chk(rd, 32'h180);
    @(posedge clk_i);
    pulse_level_i <= 1'b1;
    @(negedge clk_i);
    chk(gpio_pin_o, 32'h1);
    apb(1, `PGEU_OFF_CTRL, 32'h0);
    pulse_level_i <= 1'b0;
    @(negedge clk_i);
    chk(gpio_pin_o, 32'h1);
    end_of_test;
  end
endmodule
